/* File: logic/ftc_mac_top.sv */
// forward traffic mac assignment tracker with apb registers

`include "ftc_params.svh"
module ftc_mac_top
	import ftc_pkg::*;
(
	// clock, reset, enable
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ce,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// signalling mac side
	input  wire assign_block_t blk,
	input  wire logic          frame_start,
	input  wire logic          tuned_away_indication,
	// downlink data channel side
	input  wire logic          slot_valid,
	input  wire logic [2:0]    slot_il,
	input  wire harq_t         harq_in,
	output dch_cfg_t           dch_cfg,
	output harq_t              harq_out,
	output logic               rx_enable
);

	localparam int NIL  = `NUM_IL;
	localparam int NCAR = `NUM_CAR;
	localparam int HPW  = `HP_W;

	// overlap in time between an extended and a standard interlace
	function automatic logic overlaps(input logic [2:0] a, input logic [2:0] b);
		overlaps = (a[2] && !b[2] && (b[1] == a[0])) || (b[2] && !a[2] && (a[1] == b[0]));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers and bus

	logic [3:0]  ctrl;
	mac_state_t  state;
	logic        enter_active;
	logic        enter_inactive;
	logic [31:0] rd_data;

	// access decode
	wire setup     = psel && !penable;
	wire wr_take   = psel && penable && pready && pwrite;
	wire aligned   = (paddr[1:0] == 2'b00);
	wire [2:0] idx = paddr[4:2];
	wire idx_ok    = (idx < 3'(NIL));
	wire hit_ctrl  = aligned && (paddr == `REG_CTRL);
	wire hit_stat  = aligned && (paddr == `REG_STATUS);
	wire hit_cmd   = aligned && (paddr == `REG_CMD);
	wire hit_stk   = aligned && idx_ok && (paddr[11:5] == `PAGE_STK);
	wire hit_nsuc  = aligned && idx_ok && (paddr[11:5] == `PAGE_NSUC);
	wire hit_bc    = aligned && idx_ok && (paddr[11:5] == `PAGE_BC);
	wire mapped    = hit_ctrl || hit_stat || hit_cmd || hit_stk || hit_nsuc || hit_bc;

	// control fields
	wire       fdd_on               = ctrl[`CTRL_FDD];
	wire       implicit_deassign_on = ctrl[`CTRL_IMPL];
	wire [1:0] tree_select          = ctrl[`CTRL_TREE +: 2];

	// command pulses
	wire cmd_wr     = wr_take && hit_cmd;
	wire activate   = cmd_wr && pwdata[`CMD_ACT];
	wire deactivate = cmd_wr && pwdata[`CMD_DEACT];
	wire swap       = cmd_wr && pwdata[`CMD_SWAP];

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ctrl <= `CTRL_RESET;
		else if (ce && wr_take && hit_ctrl) ctrl <= pwdata[3:0];
	end

	// one wait-free access phase, answer registered at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (ce) begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= (setup && !pwrite) ? rd_data : 32'h0;
		end
	end

	mac_state_ctrl u_state (
		.pclk           (pclk),
		.presetn        (presetn),
		.ce             (ce),
		.activate       (activate),
		.deactivate     (deactivate),
		.swap           (swap),
		.state          (state),
		.enter_active   (enter_active),
		.enter_inactive (enter_inactive)
	);

	wire is_active = (state == ST_ACTIVE);
	wire wipe      = enter_inactive;

	////////////////////////////////////////////////////////////////////////
	// block intake

	logic [HPW-1:0] dec_mask;

	hop_port_decoder u_dec (
		.node        (blk.node),
		.tree_select (tree_select),
		.mask        (dec_mask)
	);

	// extended blocks map to interlaces 4 and 5
	wire [2:0]  eff_il = blk.extended ? {2'b10, blk.il[0]} : {1'b0, blk.il};
	wire        blk_ok = is_active && blk.valid && (!blk.extended || fdd_on);
	wire        blk_stk  = blk_ok && (blk.kind == KIND_STICKY) && (blk.btype != 2'h3);
	wire        blk_nsuc = blk_ok && (blk.kind == KIND_NS_UC) && (blk.btype != 2'h3);
	wire        blk_bc   = blk_ok && (blk.kind == KIND_NS_BC) && (blk.btype == BT_PLAIN);
	wire [31:0] placed = blk.carrier ? {dec_mask, 16'h0} : {16'h0, dec_mask};
	wire        tuned_wipe = tuned_away_indication && implicit_deassign_on;

	// assignment state per interlace
	logic [31:0]    stk_mask  [NIL];
	block_type_t    stk_type  [NIL];
	logic [31:0]    nsuc_mask [NIL];
	block_type_t    nsuc_type [NIL];
	logic           nsuc_seen [NIL];
	logic [HPW-1:0] bc_mask   [NIL][NCAR];
	logic           bc_seen   [NIL][NCAR];
	logic [1:0]     layer_count [NIL];
	logic [31:0]    comb_mask [NIL];
	logic [NIL-1:0] stk_acc;
	logic [NIL-1:0] nsuc_acc;
	logic [NIL-1:0] stk_ne;
	logic [NIL-1:0] nsuc_ne;
	logic [NIL-1:0] layer_nz;

	wire stk_any  = |stk_acc;
	wire nsuc_any = |nsuc_acc;

	for (genvar i = 0; i < NIL; i++) begin : g_il
		localparam logic [2:0] IDX = 3'(i);

		// target and time overlap
		wire tgt   = (eff_il == IDX);
		wire ovl   = fdd_on && overlaps(IDX, eff_il);
		wire fresh = !nsuc_seen[i] || frame_start;
		wire hit   = harq_in.valid && (harq_in.il == IDX);

		// acceptance against held type and content
		assign stk_ne[i]   = |stk_mask[i];
		assign nsuc_ne[i]  = |nsuc_mask[i];
		assign layer_nz[i] = |layer_count[i];
		assign stk_acc[i]  = blk_stk && tgt && !tuned_wipe &&
			(!blk.supplemental || (stk_ne[i] && stk_type[i] == blk.btype));
		assign nsuc_acc[i] = blk_nsuc && tgt && (fresh || nsuc_type[i] == blk.btype);

		// removal by rival or overlapping sets
		wire stk_kill  = tuned_wipe || nsuc_acc[i] || (ovl && (stk_any || nsuc_any));
		wire nsuc_kill = stk_acc[i] || (ovl && (stk_any || nsuc_any)) || hit;

		// next values
		wire [31:0] next_stk = wipe ? 32'h0 :
			stk_acc[i] ? (blk.supplemental ? (stk_mask[i] | placed) : placed) :
			stk_kill ? 32'h0 : stk_mask[i];
		wire [31:0] next_nsuc = wipe ? 32'h0 :
			nsuc_acc[i] ? (fresh ? placed : (nsuc_mask[i] | placed)) :
			nsuc_kill ? 32'h0 : nsuc_mask[i];
		wire next_seen = !wipe && (nsuc_acc[i] || (nsuc_seen[i] && !frame_start));
		wire lay_upd   = (stk_acc[i] || nsuc_acc[i]) && (blk.btype != BT_PLAIN);

		// sticky and unicast store
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stk_mask[i]  <= 32'h0;
				nsuc_mask[i] <= 32'h0;
				nsuc_seen[i] <= 1'b0;
			end else if (ce) begin
				stk_mask[i]  <= next_stk;
				nsuc_mask[i] <= next_nsuc;
				nsuc_seen[i] <= next_seen;
			end
		end

		// type attributes
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stk_type[i]  <= BT_PLAIN;
				nsuc_type[i] <= BT_PLAIN;
			end else if (ce) begin
				stk_type[i]  <= wipe ? BT_PLAIN : (stk_acc[i] ? blk.btype : stk_type[i]);
				nsuc_type[i] <= wipe ? BT_PLAIN : (nsuc_acc[i] ? blk.btype : nsuc_type[i]);
			end
		end

		// layer count
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) layer_count[i] <= 2'h0;
			else if (ce && enter_active) layer_count[i] <= 2'h0;
			else if (ce && lay_upd) layer_count[i] <= blk.layers;
		end

		// broadcast sets, one per carrier
		for (genvar c = 0; c < NCAR; c++) begin : g_car
			wire car_hit  = blk_bc && (blk.carrier == 1'(c));
			wire bc_tgt   = car_hit && tgt;
			wire bc_fresh = !bc_seen[i][c] || frame_start;
			wire [HPW-1:0] next_bc = wipe ? 16'h0 :
				bc_tgt ? (bc_fresh ? dec_mask : (bc_mask[i][c] | dec_mask)) :
				(ovl && car_hit) ? 16'h0 : bc_mask[i][c];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					bc_mask[i][c] <= 16'h0;
					bc_seen[i][c] <= 1'b0;
				end else if (ce) begin
					bc_mask[i][c] <= next_bc;
					bc_seen[i][c] <= !wipe && (bc_tgt || (bc_seen[i][c] && !frame_start));
				end
			end
		end

		// every hop-port of the interlace together
		assign comb_mask[i] = stk_mask[i] | nsuc_mask[i] | {bc_mask[i][1], bc_mask[i][0]};
	end

	////////////////////////////////////////////////////////////////////////
	// read data

	wire [2:0]  ridx  = idx_ok ? idx : 3'h0;
	wire [31:0] rd_st = {8'h0, 2'b00, nsuc_ne, 2'b00, stk_ne, 7'h0, is_active};
	assign rd_data = hit_ctrl ? {28'h0, ctrl} :
		hit_stat ? rd_st :
		hit_stk  ? stk_mask[ridx] :
		hit_nsuc ? nsuc_mask[ridx] :
		hit_bc   ? {bc_mask[ridx][1], bc_mask[ridx][0]} : 32'h0;

	////////////////////////////////////////////////////////////////////////
	// downlink outputs

	wire         slot_ok  = slot_valid && is_active && (slot_il < 3'(NIL));
	wire [2:0]   sidx     = slot_ok ? slot_il : 3'h0;
	wire [31:0]  sel_mask = comb_mask[sidx];
	wire         sel_go   = slot_ok && (sel_mask != 32'h0);
	dch_cfg_t    next_dch;
	harq_t       next_harq;

	// grouped setting and per-interlace result
	assign next_dch  = '{valid: sel_go, il: sidx, hop_ports: sel_go ? sel_mask : 32'h0,
		layers: layer_count[sidx], btype: stk_ne[sidx] ? stk_type[sidx] : nsuc_type[sidx]};
	assign next_harq = '{valid: harq_in.valid && is_active, il: harq_in.il, pass: harq_in.pass};

	// output flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dch_cfg   <= '0;
			harq_out  <= '0;
			rx_enable <= 1'b0;
		end else if (ce) begin
			dch_cfg   <= next_dch;
			harq_out  <= next_harq;
			rx_enable <= is_active;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_RX_GATED: assert property (ce |=> rx_enable == $past(is_active))
		else $error("reception not gated by state");
	AST_DCH_INACTIVE: assert property (ce && !is_active |=> !dch_cfg.valid)
		else $error("downlink setting while inactive");
	AST_TUNED: assert property (ce && tuned_wipe |=> stk_ne == '0)
		else $error("sticky sets survived tune away");
	AST_NO_COEXIST: assert property ((stk_ne & nsuc_ne) == '0)
		else $error("sticky and unicast set share interlace");
	AST_INACTIVE_EMPTY: assert property (!is_active |-> stk_ne == '0 && nsuc_ne == '0)
		else $error("sets held while inactive");
	AST_LAYERS_ZERO: assert property (enter_active |=> layer_nz == '0)
		else $error("layer count not cleared on activation");
	AST_NSUC_ONE_PKT: assert property (ce && harq_in.valid && harq_in.il < 3'(NIL) && !blk.valid
		|=> !nsuc_ne[$past(harq_in.il)])
		else $error("unicast set kept after its packet");
	AST_DCH_GROUP: assert property (ce && sel_go |=> dch_cfg.valid && dch_cfg.hop_ports == $past(sel_mask))
		else $error("downlink hop-ports not grouped");
	AST_STK_SUPP: assert property (ce && blk_stk && blk.supplemental && !stk_ne[eff_il] |-> !stk_any)
		else $error("supplement accepted on empty set");
	AST_EXT_CLEARS_STK: assert property (ce && fdd_on && stk_acc[4] |=> stk_ne[1:0] == 2'b00)
		else $error("overlapping sticky sets kept under fdd");
	AST_EXT_CLEARS_NSUC: assert property (ce && fdd_on && stk_acc[4] |=> nsuc_ne[1:0] == 2'b00)
		else $error("overlapping unicast sets kept under fdd");

	COV_STK: cover property (stk_any ##1 stk_ne != '0);
	COV_NSUC: cover property (nsuc_any ##[1:10] harq_in.valid);
	COV_BC: cover property (blk_bc && ce);
	COV_TUNED: cover property (tuned_wipe && stk_ne != '0);

endmodule

/* File: logic/ftc_params.svh */
// constants of the forward traffic assignment block
`ifndef FTC_PARAMS_SVH
`define FTC_PARAMS_SVH

// sizes
`define NUM_IL      6
`define NUM_CAR     2
`define HP_W        16

// register byte offsets and page numbers at paddr[11:5]
`define REG_CTRL    12'h000
`define REG_STATUS  12'h004
`define REG_CMD     12'h008
`define PAGE_STK    7'h01
`define PAGE_NSUC   7'h02
`define PAGE_BC     7'h03

// control fields
`define CTRL_RESET  4'h0
`define CTRL_FDD    0
`define CTRL_IMPL   1
`define CTRL_TREE   2

// command fields
`define CMD_ACT     0
`define CMD_DEACT   1
`define CMD_SWAP    2

// status fields
`define STAT_ACTIVE 0
`define STAT_STK    8
`define STAT_NSUC   16

`endif

/* File: logic/ftc_pkg.sv */
// types of the forward traffic assignment block
package ftc_pkg;

	// protocol state, one-hot
	typedef enum logic [1:0] {
		ST_INACTIVE = 2'b01,
		ST_ACTIVE   = 2'b10
	} mac_state_t;

	// block subtype within a family
	typedef enum logic [1:0] {
		BT_PLAIN = 2'h0,
		BT_SCW   = 2'h1,
		BT_MCW   = 2'h2
	} block_type_t;

	// block family
	typedef enum logic [1:0] {
		KIND_STICKY = 2'h0,
		KIND_NS_UC  = 2'h1,
		KIND_NS_BC  = 2'h2
	} block_kind_t;

	// assignment block from the signalling mac
	typedef struct packed {
		logic        valid;
		block_kind_t kind;
		block_type_t btype;
		logic [1:0]  il;
		logic        extended;
		logic        supplemental;
		logic        carrier;
		logic [7:0]  node;
		logic [1:0]  layers;
	} assign_block_t;

	// grouped downlink data channel setting
	typedef struct packed {
		logic        valid;
		logic [2:0]  il;
		logic [31:0] hop_ports;
		logic [1:0]  layers;
		block_type_t btype;
	} dch_cfg_t;

	// per-interlace packet result
	typedef struct packed {
		logic       valid;
		logic [2:0] il;
		logic       pass;
	} harq_t;

endpackage

/* File: logic/hop_port_decoder.sv */
// node to hop-port mask decode against the selected channel tree
module hop_port_decoder
	import ftc_pkg::*;
(
	// node and tree
	input  wire logic [7:0]  node,
	input  wire logic [1:0]  tree_select,
	// decoded hop-ports
	output logic [15:0] mask
);

	// level picks span, position and tree pick base
	wire [2:0]  lvl  = (node[7:5] > 3'd4) ? 3'd4 : node[7:5];
	wire [4:0]  span = 5'd1 << lvl;
	wire [16:0] full = (17'h1 << span) - 17'h1;
	wire [15:0] ones = full[15:0];
	wire [3:0]  base = 4'((node[3:0] << lvl) + {tree_select, 2'b00});
	wire [31:0] rot  = {ones, ones} << base;

	// wrapped mask
	assign mask = rot[31:16];

endmodule

/* File: logic/mac_state_ctrl.sv */
// inactive and active state control
module mac_state_ctrl
	import ftc_pkg::*;
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// commands
	input  wire logic activate,
	input  wire logic deactivate,
	input  wire logic swap,
	// state
	output mac_state_t state,
	output logic       enter_active,
	output logic       enter_inactive
);

	mac_state_t next_state;

	// transitions, swap first
	always_comb begin
		next_state = state;
		unique case (state)
			ST_INACTIVE: if (activate && !swap) next_state = ST_ACTIVE;
			ST_ACTIVE:   if (swap || deactivate) next_state = ST_INACTIVE;
		endcase
	end

	// entry pulses
	assign enter_active   = ce && (state == ST_INACTIVE) && (next_state == ST_ACTIVE);
	assign enter_inactive = ce && (state == ST_ACTIVE) && (next_state == ST_INACTIVE);

	// state register, starts inactive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state <= ST_INACTIVE;
		else if (ce) state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_ACTIVATE: assert property (ce && state == ST_INACTIVE && activate && !swap |=> state == ST_ACTIVE)
		else $error("activate did not reach active");
	AST_ACT_IGNORED: assert property (ce && state == ST_ACTIVE && !deactivate && !swap |=> $stable(state))
		else $error("activate changed active state");
	AST_DEACT: assert property (ce && state == ST_ACTIVE && deactivate |=> state == ST_INACTIVE)
		else $error("deactivate did not reach inactive");
	AST_DEACT_IGNORED: assert property (ce && state == ST_INACTIVE && !activate |=> state == ST_INACTIVE)
		else $error("inactive left without activate");
	AST_SWAP: assert property (ce && swap |=> state == ST_INACTIVE)
		else $error("swap did not reach inactive");

	COV_ACT_DEACT: cover property (enter_active ##[1:20] enter_inactive);

endmodule

/* File: test/assignment_source.sv */
// signalling mac stand-in that sends assignment blocks, results and tune-away pulses
module assignment_source
	import ftc_pkg::*;
(
	// clock
	input  wire logic     pclk,
	// toward the tracker
	output assign_block_t blk,
	output logic          frame_start,
	output logic          tuned_away_indication,
	output harq_t         harq_in
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////
	// idle levels at time zero
	initial begin
		blk = '0;
		frame_start = 1'b0;
		tuned_away_indication = 1'b0;
		harq_in = '0;
	end

	// one block for one cycle; unqualified fields are scrambled afterwards
	task automatic send(input block_kind_t k, input block_type_t t, input logic [1:0] il,
		input logic ext, input logic sup, input logic car, input logic [7:0] node, input logic fr);
		@(posedge pclk);
		blk <= '{1'b1, k, t, il, ext, sup, car, node, 2'h1};
		frame_start <= fr;
		@(posedge pclk);
		blk <= {1'b0, ~blk[$bits(blk)-2:0]};
		frame_start <= 1'b0;
	endtask

	// packet result pulse for one interlace
	task automatic result(input logic [2:0] il, input logic ok);
		@(posedge pclk);
		harq_in <= '{1'b1, il, ok};
		@(posedge pclk);
		harq_in <= '{1'b0, ~il, ~ok};
	endtask

	// tune-away pulse
	task automatic tune_away();
		@(posedge pclk);
		tuned_away_indication <= 1'b1;
		@(posedge pclk);
		tuned_away_indication <= 1'b0;
	endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench of the forward traffic assignment tracker
`include "ftc_params.svh"
module tb_top
	import ftc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		string       what;
		logic [32:0] exp;
		logic [32:0] msk;
	} note_t;

	localparam logic [32:0] ALL = 33'h1_ffff_ffff;

	logic          pclk;
	logic          presetn;
	logic          ce;
	logic          psel;
	logic          penable;
	logic          pwrite;
	logic [11:0]   paddr;
	logic [31:0]   pwdata;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	assign_block_t blk;
	logic          frame_start;
	logic          tuned_away_indication;
	logic          slot_valid;
	logic [2:0]    slot_il;
	harq_t         harq_in;
	dch_cfg_t      dch_cfg;
	harq_t         harq_out;
	logic          rx_enable;
	int            fails;
	int            comparisons;
	logic [31:0]   seed;
	logic [7:0]    nd;
	logic [15:0]   acc;
	note_t         notes[$];

	////////////////////////////////////////////////////////////////
	// device and far side
	ftc_mac_top i_ftc_mac_top (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.blk(blk), .frame_start(frame_start), .tuned_away_indication(tuned_away_indication),
		.slot_valid(slot_valid), .slot_il(slot_il), .harq_in(harq_in), .dch_cfg(dch_cfg),
		.harq_out(harq_out), .rx_enable(rx_enable));
	assignment_source i_assignment_source (
		.pclk(pclk), .blk(blk), .frame_start(frame_start),
		.tuned_away_indication(tuned_away_indication), .harq_in(harq_in));

	// clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic final_report();
		if (fails == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// compare one result with the oldest note
	task automatic check(input string what, input logic [32:0] seen);
		note_t nt;
		comparisons++;
		if (notes.size() == 0) begin
			fails++;
			$display("unexpected %s expected none seen %h", what, seen);
		end else begin
			nt = notes.pop_front();
			if (nt.what != what || (seen & nt.msk) !== (nt.exp & nt.msk)) begin
				fails++;
				$display("unexpected %s expected %h seen %h", nt.what, nt.exp & nt.msk, seen & nt.msk);
			end
		end
	endtask

	function automatic void note(input string what, input logic [32:0] exp, input logic [32:0] msk);
		notes.push_back('{what, exp, msk});
	endfunction

	// level compare through the same note path
	task automatic direct(input string what, input logic seen, input logic exp);
		@(negedge pclk);
		note(what, {32'h0, exp}, 33'h1);
		check(what, {32'h0, seen});
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fails++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] exp, input logic [32:0] msk);
		note($sformatf("read %h", a), exp, msk);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic cmd(input logic [2:0] c);
		apb(1'b1, `REG_CMD, {29'h0, c});
	endtask

	// flags are {extended, supplemental, carrier, frame start}
	task automatic snd(input block_kind_t k, input block_type_t t, input logic [1:0] il,
		input logic [3:0] f, input logic [7:0] node);
		i_assignment_source.send(k, t, il, f[3], f[2], f[1], node, f[0]);
	endtask

	task automatic harq(input logic [2:0] il, input logic ok);
		note("harq", {29'h0, il, ok}, ALL);
		i_assignment_source.result(il, ok);
	endtask

	task automatic slot(input logic [2:0] il, input logic [15:0] hp0, input logic [1:0] lay, input block_type_t bt);
		note("dch", {17'h0, hp0}, ALL);
		note("dch attr", {26'h0, il, lay, bt}, ALL);
		@(posedge pclk);
		slot_valid <= 1'b1;
		slot_il <= il;
		@(posedge pclk);
		slot_valid <= 1'b0;
	endtask

	function automatic logic [11:0] sa(input logic [6:0] page, input logic [2:0] il);
		return {page, il, 2'b00};
	endfunction

	// expected hop-port mask of a node under a tree choice
	function automatic logic [15:0] hp(input logic [7:0] n, input logic [1:0] t);
		int lv;
		int base;
		logic [31:0] x;
		lv = (n[7:5] > 3'h4) ? 4 : int'(n[7:5]);
		base = ((int'(n[3:0]) << lv) + 4 * int'(t)) % 16;
		x = ((32'h1 << (1 << lv)) - 32'h1) << base;
		return x[15:0] | x[31:16];
	endfunction

	////////////////////////////////////////////////////////////////
	// result watcher
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			check($sformatf("read %h", paddr), {pslverr, prdata});
		end
		if (dch_cfg.valid === 1'b1) begin
			check("dch", {1'b0, dch_cfg.hop_ports});
			check("dch attr", {26'h0, dch_cfg.il, dch_cfg.layers, dch_cfg.btype});
		end
		if (harq_out.valid === 1'b1) begin
			check("harq", {29'h0, harq_out.il, harq_out.pass});
		end
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		ce = 1'b1;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		slot_valid = 1'b0;
		slot_il = 3'h0;
		fails = 0;
		comparisons = 0;
		seed = $urandom(32'heef10643);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// defaults, refused address, nothing taken while inactive
		rd(`REG_STATUS, 33'h0, ALL);
		rd(`REG_CTRL, 33'h0, ALL);
		rd(12'h0f0, 33'h1_0000_0000, ALL);
		snd(KIND_STICKY, BT_PLAIN, 2'h0, 4'h1, 8'h00);
		i_assignment_source.result(3'h0, 1'b1);
		rd(sa(`PAGE_STK, 3'h0), 33'h0, ALL);
		cmd(3'h2);
		rd(`REG_STATUS, 33'h0, ALL);
		cmd(3'h1);
		rd(`REG_STATUS, 33'h1, 33'h1);
		direct("rx_enable", rx_enable, 1'b1);
		// random nodes under every tree choice
		for (int t = 0; t < 4; t++) begin
			nd = 8'($urandom);
			wr(`REG_CTRL, {28'h0, t[1:0], 2'b00});
			snd(KIND_STICKY, BT_PLAIN, 2'h2, 4'h1, nd);
			rd(sa(`PAGE_STK, 3'h2), {17'h0, hp(nd, t[1:0])}, ALL);
		end
		// frozen clock enable takes no block
		ce <= 1'b0;
		snd(KIND_STICKY, BT_PLAIN, 2'h3, 4'h1, 8'h00);
		ce <= 1'b1;
		rd(sa(`PAGE_STK, 3'h3), 33'h0, ALL);
		// sticky accumulation across frames, rival type refused
		wr(`REG_CTRL, 32'h0);
		acc = hp(8'h00, 2'h0) | hp(8'h25, 2'h0);
		snd(KIND_STICKY, BT_SCW, 2'h1, 4'h1, 8'h00);
		snd(KIND_STICKY, BT_SCW, 2'h1, 4'h5, 8'h25);
		rd(sa(`PAGE_STK, 3'h1), {17'h0, acc}, ALL);
		snd(KIND_STICKY, BT_MCW, 2'h1, 4'h5, 8'h09);
		cmd(3'h1);
		rd(sa(`PAGE_STK, 3'h1), {17'h0, acc}, ALL);
		harq(3'h1, 1'b0);
		slot(3'h1, acc, 2'h1, BT_SCW);
		// unicast displaces sticky and accumulates within one frame only
		snd(KIND_NS_UC, BT_PLAIN, 2'h1, 4'h1, 8'h02);
		rd(`REG_STATUS, 33'h2_0000, 33'h2_0200);
		snd(KIND_NS_UC, BT_PLAIN, 2'h1, 4'h0, 8'h03);
		snd(KIND_NS_UC, BT_SCW, 2'h1, 4'h0, 8'h07);
		rd(sa(`PAGE_NSUC, 3'h1), {17'h0, hp(8'h02, 2'h0) | hp(8'h03, 2'h0)}, ALL);
		snd(KIND_NS_UC, BT_PLAIN, 2'h1, 4'h1, 8'h06);
		rd(sa(`PAGE_NSUC, 3'h1), {17'h0, hp(8'h06, 2'h0)}, ALL);
		harq(3'h1, 1'b1);
		rd(sa(`PAGE_NSUC, 3'h1), 33'h0, ALL);
		// broadcast only from plain blocks, one set per carrier
		snd(KIND_NS_BC, BT_SCW, 2'h3, 4'h3, 8'h01);
		snd(KIND_NS_BC, BT_PLAIN, 2'h3, 4'h2, 8'h01);
		snd(KIND_NS_BC, BT_PLAIN, 2'h3, 4'h0, 8'h04);
		rd(sa(`PAGE_BC, 3'h3), {1'b0, hp(8'h01, 2'h0), hp(8'h04, 2'h0)}, ALL);
		// extended frames only with fdd, overlap clears standard set
		snd(KIND_STICKY, BT_PLAIN, 2'h0, 4'h9, 8'h00);
		rd(`REG_STATUS, 33'h0, 33'h1000);
		wr(`REG_CTRL, 32'h1);
		snd(KIND_STICKY, BT_PLAIN, 2'h0, 4'h1, 8'h00);
		snd(KIND_STICKY, BT_PLAIN, 2'h0, 4'h9, 8'h04);
		rd(`REG_STATUS, 33'h1000, 33'h1100);
		rd(sa(`PAGE_STK, 3'h4), {17'h0, hp(8'h04, 2'h0)}, ALL);
		// tune-away with implicit deassign expires sticky sets
		wr(`REG_CTRL, 32'h3);
		i_assignment_source.tune_away();
		rd(`REG_STATUS, 33'h0, 33'h3f00);
		// deactivate wipes, swap returns inactive
		cmd(3'h2);
		rd(`REG_STATUS, 33'h0, ALL);
		direct("rx_enable", rx_enable, 1'b0);
		cmd(3'h1);
		rd(sa(`PAGE_BC, 3'h3), 33'h0, ALL);
		cmd(3'h4);
		rd(`REG_STATUS, 33'h0, 33'h1);
		repeat (4) @(posedge pclk);
		if (notes.size() != 0) begin
			fails++;
			$display("unexpected pending notes expected 0 seen %0d", notes.size());
		end
		final_report();
	end
endmodule
